// file: logic/dfb_pkg.sv
package dfb_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int DFB_DATA_W = 36;
    localparam int DFB_WORD_W = 18;
    localparam int DFB_BYTE_W = 9;
    localparam int DFB_DEPTH = 256;
    localparam int DFB_ADDR_W = 8;
    localparam int DFB_PTR_W = 9;

    // ************************************************************
    // Flag thresholds and timing
    // ************************************************************
    localparam logic [8:0] DFB_DEPTH_CNT = 9'h100;
    localparam logic [8:0] DFB_AE_OFFSET = 9'h008;
    localparam logic [8:0] DFB_AF_OFFSET = 9'h008;
    localparam int DFB_SYNC_STAGES = 2;
    localparam real DFB_CLK_MHZ = 20.0;

    // ************************************************************
    // Port B sizing
    // ************************************************************
    localparam logic [1:0] DFB_PIECES_LONG = 2'h0;
    localparam logic [1:0] DFB_PIECES_WORD = 2'h1;
    localparam logic [1:0] DFB_PIECES_BYTE = 2'h3;

    typedef enum logic [1:0] {
        DFB_SIZE_LONG,
        DFB_SIZE_WORD,
        DFB_SIZE_BYTE
    } dfb_size_t;

    // ************************************************************
    // Port access strobes
    // ************************************************************
    typedef struct packed {
        logic chip_select_n;
        logic direction;
        logic mailbox_select;
        logic enable;
    } dfb_ctl_t;

    typedef struct packed {
        logic output_ready;
        logic empty_n;
        logic input_ready;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
        logic mailbox_full;
    } dfb_flags_t;

endpackage

// file: logic/dfb_top.sv
`timescale 1ns/1ps
// Operation
// - Byte size: forward entry leaves port B in four bytes, endian ordered.
// - Fall-through: port B output ready and data within three cycles.
// - Narrow sizes: port B ready or empty drops on last piece read.
// - Standard mode: port B empty released after forward write crosses.
// - Fall-through: port A output ready within three cycles of entry.
// - Standard mode: port A empty released after reverse entry completes.
// - Port B read of full forward queue releases port A full.
// - Port A read releases port B full; it falls on last piece.
// - Port B almost-empty follows forward level, set on last piece.
// - Port A almost-empty released after reverse write crosses.
// - Port A almost-full released once level below depth minus offset.
// - Port B almost-full released after port A read; last piece sets.
// - Queues hold 256 entries of 36 bits; threshold uses depth.
// - Forward mailbox passes bits 0-17 word, 0-8 byte to port B.
// - Reverse mailbox passes bits 0-17 word, 0-8 byte to port A.
// - Narrow writes ignore unused upper port B input lines.
module dfb_top
    import dfb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_match_select,
    input wire logic size_select,
    input wire logic endian_select,
    input wire logic fall_through_mode,
    input wire dfb_ctl_t a_ctl,
    input wire logic [35:0] a_data_in,
    output logic [35:0] a_data_out,
    output dfb_flags_t a_flags,
    input wire dfb_ctl_t b_ctl,
    input wire logic [35:0] b_data_in,
    output logic [35:0] b_data_out,
    output dfb_flags_t b_flags
);

    // ************************************************************
    // Access decode
    // ************************************************************
    logic a_sel;
    logic b_sel;
    logic fwd_wr;
    logic rev_rd_req;
    logic fwd_mbx_wr;
    logic rev_mbx_rd;
    logic fwd_rd_req;
    logic rev_wr_req;
    logic rev_mbx_wr;
    logic fwd_mbx_rd;
    logic fwd_full;
    logic rev_full;
    assign a_sel = !a_ctl.chip_select_n && a_ctl.enable;
    assign b_sel = !b_ctl.chip_select_n && b_ctl.enable;
    assign fwd_wr = a_sel && a_ctl.direction && !a_ctl.mailbox_select
        && !fwd_full;
    assign rev_rd_req = a_sel && !a_ctl.direction && !a_ctl.mailbox_select;
    assign fwd_mbx_wr = a_sel && a_ctl.direction && a_ctl.mailbox_select;
    assign rev_mbx_rd = a_sel && !a_ctl.direction && a_ctl.mailbox_select;
    assign fwd_rd_req = b_sel && b_ctl.direction && !b_ctl.mailbox_select;
    assign rev_wr_req = b_sel && !b_ctl.direction && !b_ctl.mailbox_select
        && !rev_full;
    assign rev_mbx_wr = b_sel && !b_ctl.direction && b_ctl.mailbox_select;
    assign fwd_mbx_rd = b_sel && b_ctl.direction && b_ctl.mailbox_select;

    // ************************************************************
    // Sizing and endian strap
    // ************************************************************
    logic endian_q;
    logic strap_done_q;
    dfb_size_t size;
    logic [1:0] last_piece;
    assign size = !bus_match_select ? DFB_SIZE_LONG :
        (size_select ? DFB_SIZE_BYTE : DFB_SIZE_WORD);
    assign last_piece = (size == DFB_SIZE_LONG) ? DFB_PIECES_LONG :
        (size == DFB_SIZE_WORD) ? DFB_PIECES_WORD : DFB_PIECES_BYTE;

    // Endian is caught once, on the first edge after reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            endian_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            endian_q <= endian_select;
            strap_done_q <= 1'b1;
        end
    end

    // Slot index of a piece within a long word
    function automatic logic [1:0] slot_of(input logic [1:0] piece,
            input logic [1:0] last, input logic big);
        slot_of = big ? last - piece : piece;
    endfunction

    // Piece of a long word, right justified, upper bits zero
    function automatic logic [35:0] piece_of(input logic [35:0] entry,
            input logic [1:0] piece, input dfb_size_t sz, input logic big);
        logic [1:0] s;
        s = 2'h0;
        piece_of = entry;
        if (sz == DFB_SIZE_WORD) begin
            s = slot_of(piece, DFB_PIECES_WORD, big);
            piece_of = {18'h00000, entry[s[0]*DFB_WORD_W +: DFB_WORD_W]};
        end else if (sz == DFB_SIZE_BYTE) begin
            s = slot_of(piece, DFB_PIECES_BYTE, big);
            piece_of = {27'h0000000, entry[s*DFB_BYTE_W +: DFB_BYTE_W]};
        end
    endfunction

    // ************************************************************
    // Queue storage and pointers
    // ************************************************************
    logic [35:0] fwd_mem [DFB_DEPTH];
    logic [35:0] rev_mem [DFB_DEPTH];
    logic [8:0] fwd_wp_q;
    logic [8:0] fwd_rp_q;
    logic [8:0] rev_wp_q;
    logic [8:0] rev_rp_q;
    logic [8:0] fwd_done_q;
    logic [8:0] rev_done_q;
    logic [8:0] fwd_wp_s_q [DFB_SYNC_STAGES];
    logic [8:0] fwd_rp_s_q [DFB_SYNC_STAGES];
    logic [8:0] rev_wp_s_q [DFB_SYNC_STAGES];
    logic [8:0] rev_rp_s_q [DFB_SYNC_STAGES];

    // Pointer crossings, two stages each way
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DFB_SYNC_STAGES; i++) begin
                fwd_wp_s_q[i] <= 9'h000;
                fwd_rp_s_q[i] <= 9'h000;
                rev_wp_s_q[i] <= 9'h000;
                rev_rp_s_q[i] <= 9'h000;
            end
        end else begin
            fwd_wp_s_q[0] <= fwd_wp_q;
            fwd_rp_s_q[0] <= fwd_done_q; // Freed only once fully read
            rev_wp_s_q[0] <= rev_wp_q;
            rev_rp_s_q[0] <= rev_done_q;
            for (int i = 1; i < DFB_SYNC_STAGES; i++) begin
                fwd_wp_s_q[i] <= fwd_wp_s_q[i-1];
                fwd_rp_s_q[i] <= fwd_rp_s_q[i-1];
                rev_wp_s_q[i] <= rev_wp_s_q[i-1];
                rev_rp_s_q[i] <= rev_rp_s_q[i-1];
            end
        end
    end

    // ************************************************************
    // Fill levels as seen by each side
    // ************************************************************
    logic [8:0] fwd_lvl_a;
    logic [8:0] fwd_avail_b;
    logic [8:0] rev_lvl_b;
    logic [8:0] rev_avail_a;
    assign fwd_lvl_a = fwd_wp_q - fwd_rp_s_q[DFB_SYNC_STAGES-1];
    assign fwd_avail_b = fwd_wp_s_q[DFB_SYNC_STAGES-1] - fwd_rp_q;
    assign rev_lvl_b = rev_wp_q - rev_rp_s_q[DFB_SYNC_STAGES-1];
    assign rev_avail_a = rev_wp_s_q[DFB_SYNC_STAGES-1] - rev_rp_q;
    assign fwd_full = (fwd_lvl_a == DFB_DEPTH_CNT);
    assign rev_full = (rev_lvl_b == DFB_DEPTH_CNT);

    // ************************************************************
    // Forward queue: port A write, port B piecewise read
    // ************************************************************
    logic [35:0] fwd_head_q;
    logic fwd_head_v_q;
    logic [1:0] fwd_piece_q;
    logic fwd_rd;
    logic fwd_last;
    logic fwd_pull;
    assign fwd_rd = fwd_rd_req && fwd_head_v_q;
    assign fwd_last = fwd_rd && (fwd_piece_q == last_piece);
    assign fwd_pull = (!fwd_head_v_q || fwd_last) && (fwd_avail_b != 9'h000);

    // Next head state; ready and empty flags and fall-through data follow it, not the past
    logic [1:0] fwd_piece_d;
    logic [35:0] fwd_head_d;
    logic fwd_head_v_d;
    assign fwd_piece_d = !fwd_rd ? fwd_piece_q :
        (fwd_last ? 2'h0 : fwd_piece_q + 2'h1);
    assign fwd_head_d = fwd_pull ? fwd_mem[fwd_rp_q[7:0]] : fwd_head_q;
    assign fwd_head_v_d = fwd_pull || (fwd_head_v_q && !fwd_last);

    // Port A write into forward storage
    always_ff @(posedge clock) begin
        if (fwd_wr) begin
            fwd_mem[fwd_wp_q[7:0]] <= a_data_in;
        end
    end

    // Head register fetch and piece count on port B
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fwd_wp_q <= 9'h000;
            fwd_rp_q <= 9'h000;
            fwd_head_q <= 36'h000000000;
            fwd_head_v_q <= 1'b0;
            fwd_piece_q <= 2'h0;
            fwd_done_q <= 9'h000;
        end else begin
            if (fwd_wr) begin
                fwd_wp_q <= fwd_wp_q + 9'h001;
            end
            fwd_piece_q <= fwd_piece_d;
            fwd_head_q <= fwd_head_d;
            fwd_head_v_q <= fwd_head_v_d;
            if (fwd_pull) begin
                fwd_rp_q <= fwd_rp_q + 9'h001;
            end
            if (fwd_last) begin
                fwd_done_q <= fwd_done_q + 9'h001;
            end
        end
    end

    // ************************************************************
    // Reverse queue: port B piecewise write, port A read
    // ************************************************************
    logic [35:0] rev_asm_q;
    logic [1:0] rev_piece_q;
    logic [1:0] rev_slot;
    logic [35:0] rev_asm_d;
    logic rev_commit;
    logic [35:0] rev_head_q;
    logic rev_head_v_q;
    logic rev_rd;
    logic rev_pull;
    assign rev_slot = slot_of(rev_piece_q, last_piece, endian_q);
    assign rev_commit = rev_wr_req && (rev_piece_q == last_piece);

    // Drop the new piece into its slot, upper inputs ignored
    always_comb begin
        rev_asm_d = rev_asm_q;
        case (size)
            DFB_SIZE_WORD: rev_asm_d[rev_slot[0]*DFB_WORD_W +: DFB_WORD_W] =
                b_data_in[17:0];
            DFB_SIZE_BYTE: rev_asm_d[rev_slot*DFB_BYTE_W +: DFB_BYTE_W] =
                b_data_in[8:0];
            default: rev_asm_d = b_data_in;
        endcase
    end

    assign rev_rd = rev_rd_req && rev_head_v_q;
    assign rev_pull = (!rev_head_v_q || rev_rd) && (rev_avail_a != 9'h000);
    logic rev_head_v_d;
    assign rev_head_v_d = rev_pull || (rev_head_v_q && !rev_rd);

    // Port B commit of a whole long word
    always_ff @(posedge clock) begin
        if (rev_commit) begin
            rev_mem[rev_wp_q[7:0]] <= rev_asm_d;
        end
    end

    // Assembly on port B and head fetch on port A
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rev_wp_q <= 9'h000;
            rev_rp_q <= 9'h000;
            rev_asm_q <= 36'h000000000;
            rev_piece_q <= 2'h0;
            rev_head_q <= 36'h000000000;
            rev_head_v_q <= 1'b0;
            rev_done_q <= 9'h000;
        end else begin
            if (rev_wr_req) begin
                rev_asm_q <= rev_asm_d;
                rev_piece_q <= rev_commit ? 2'h0 : rev_piece_q + 2'h1;
            end
            if (rev_commit) begin
                rev_wp_q <= rev_wp_q + 9'h001;
            end
            rev_head_v_q <= rev_head_v_d;
            if (rev_pull) begin
                rev_head_q <= rev_mem[rev_rp_q[7:0]];
                rev_rp_q <= rev_rp_q + 9'h001;
            end
            if (rev_rd) begin
                rev_done_q <= rev_done_q + 9'h001;
            end
        end
    end

    // ************************************************************
    // Mailboxes
    // ************************************************************
    logic [35:0] fwd_mbx_q;
    logic [35:0] rev_mbx_q;
    logic fwd_mbx_full_q;
    logic rev_mbx_full_q;
    logic [35:0] narrow_mask;
    assign narrow_mask = (size == DFB_SIZE_WORD) ? 36'h00003ffff :
        (size == DFB_SIZE_BYTE) ? 36'h0000001ff : 36'hfffffffff;

    // Full flags: sender sets, receiver read clears, set wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fwd_mbx_q <= 36'h000000000;
            rev_mbx_q <= 36'h000000000;
            fwd_mbx_full_q <= 1'b0;
            rev_mbx_full_q <= 1'b0;
        end else begin
            if (fwd_mbx_wr) begin
                fwd_mbx_q <= a_data_in & narrow_mask;
            end
            if (rev_mbx_wr) begin
                rev_mbx_q <= b_data_in & narrow_mask;
            end
            fwd_mbx_full_q <= fwd_mbx_wr ||
                (fwd_mbx_full_q && !fwd_mbx_rd);
            rev_mbx_full_q <= rev_mbx_wr ||
                (rev_mbx_full_q && !rev_mbx_rd);
        end
    end

    // ************************************************************
    // Data outputs and flags
    // ************************************************************
    logic [35:0] b_piece;
    logic [8:0] fwd_lvl_b;
    assign b_piece = fall_through_mode ?
        piece_of(fwd_head_d, fwd_piece_d, size, endian_q) :
        piece_of(fwd_head_q, fwd_piece_q, size, endian_q);
    assign fwd_lvl_b = fwd_avail_b + {8'h00, fwd_head_v_q};

    // Output buses: fall-through shows the head, standard updates on read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            a_data_out <= 36'h000000000;
            b_data_out <= 36'h000000000;
        end else begin
            if (rev_mbx_rd) begin
                a_data_out <= rev_mbx_q;
            end else if (rev_rd || (fall_through_mode && rev_pull)) begin
                a_data_out <= rev_rd && !fall_through_mode ? rev_head_q :
                    rev_mem[rev_rp_q[7:0]];
            end
            if (fwd_mbx_rd) begin
                b_data_out <= fwd_mbx_q;
            end else if (fall_through_mode || fwd_rd) begin
                b_data_out <= b_piece;
            end
        end
    end

    // Status flags, each registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            a_flags <= '0;
            b_flags <= '0;
        end else begin
            b_flags.output_ready <= fall_through_mode && fwd_head_v_d;
            b_flags.empty_n <= !fall_through_mode && fwd_head_v_d;
            a_flags.output_ready <= fall_through_mode && rev_head_v_d;
            a_flags.empty_n <= !fall_through_mode && rev_head_v_d;
            a_flags.input_ready <= fall_through_mode && !fwd_full;
            a_flags.full_n <= !fall_through_mode && !fwd_full;
            b_flags.input_ready <= fall_through_mode && !rev_full;
            b_flags.full_n <= !fall_through_mode && !rev_full;
            b_flags.almost_empty_n <= fwd_lvl_b > DFB_AE_OFFSET;
            a_flags.almost_empty_n <=
                (rev_avail_a + {8'h00, rev_head_v_q}) > DFB_AE_OFFSET;
            a_flags.almost_full_n <=
                fwd_lvl_a < (DFB_DEPTH_CNT - DFB_AF_OFFSET);
            b_flags.almost_full_n <=
                rev_lvl_b < (DFB_DEPTH_CNT - DFB_AF_OFFSET);
            a_flags.mailbox_full <= fwd_mbx_full_q;
            b_flags.mailbox_full <= rev_mbx_full_q;
        end
    end

endmodule

// file: dv/dfb_b_reader.sv
`timescale 1ns/1ps
module dfb_b_reader
    import dfb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rd_go,
    input wire dfb_flags_t b_flags,
    output dfb_ctl_t b_ctl = 4'h8
);
    // ****************
    // Port B reader
    // ****************
    logic [2:0] pace_q = 3'h0;
    wire avail = b_flags.output_ready || b_flags.empty_n;
    // Strobe moves at the falling edge; one stall in eight cycles
    always @(negedge clock) begin
        pace_q <= rst_n ? pace_q + 3'h1 : 3'h0;
        if (rd_go && rst_n && avail && pace_q != 3'h5) begin
            b_ctl <= 4'h5;
        end else begin
            b_ctl <= 4'h8;
        end
    end
endmodule

// file: dv/dfb_properties.sv
`timescale 1ns/1ps
module dfb_properties
    import dfb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_match_select,
    input wire logic size_select,
    input wire logic endian_select,
    input wire logic fall_through_mode,
    input wire dfb_ctl_t a_ctl,
    input wire logic [35:0] a_data_in,
    input wire logic [35:0] a_data_out,
    input wire dfb_flags_t a_flags,
    input wire dfb_ctl_t b_ctl,
    input wire logic [35:0] b_data_in,
    input wire logic [35:0] b_data_out,
    input wire dfb_flags_t b_flags
);
    // ****************
    // Strobe decode
    // ****************
    wire a_on = !a_ctl.chip_select_n && a_ctl.enable;
    wire b_on = !b_ctl.chip_select_n && b_ctl.enable;
    wire a_wr = a_on && a_ctl.direction && !a_ctl.mailbox_select;
    wire a_rd = a_on && !a_ctl.direction && !a_ctl.mailbox_select;
    wire a_mw = a_on && a_ctl.direction && a_ctl.mailbox_select;
    wire b_rd = b_on && b_ctl.direction && !b_ctl.mailbox_select;
    wire b_mr = b_on && b_ctl.direction && b_ctl.mailbox_select;
    wire a_av = a_flags.output_ready || a_flags.empty_n;
    wire b_av = b_flags.output_ready || b_flags.empty_n;
    wire word_b = bus_match_select && !size_select;
    wire ft_long = fall_through_mode && !bus_match_select;
    logic [35:0] mbx_q;
    // Last word posted to the forward mailbox
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mbx_q <= 36'h0;
        end else if (a_mw) begin
            mbx_q <= a_data_in;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_b_avail;
        a_wr && !b_av |-> ##[1:4] b_av;
    endproperty
    a_b_avail: assert property (p_b_avail)
        else $error("port B data flag late");
    property p_b_drop;
        $fell(b_av) |-> $past(b_rd && b_av);
    endproperty
    a_b_drop: assert property (p_b_drop)
        else $error("port B data flag fell without a read");
    property p_a_drop;
        $fell(a_av) |-> $past(a_rd && a_av);
    endproperty
    a_a_drop: assert property (p_a_drop)
        else $error("port A data flag fell without a read");
    property p_full_set;
        $fell(a_flags.input_ready) |-> $past(a_wr, 2);
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("port A ready fell without a write");
    property p_full_rel;
        ft_long && !a_flags.input_ready && b_rd && b_av
            |-> ##[1:4] a_flags.input_ready;
    endproperty
    a_full_rel: assert property (p_full_rel)
        else $error("port A ready not released");
    property p_mb_set;
        a_mw |-> ##[1:3] a_flags.mailbox_full;
    endproperty
    a_mb_set: assert property (p_mb_set)
        else $error("forward mailbox flag not set");
    property p_mb_clr;
        a_flags.mailbox_full && b_mr && !a_mw |-> ##[1:3] !a_flags.mailbox_full;
    endproperty
    a_mb_clr: assert property (p_mb_clr)
        else $error("forward mailbox flag not cleared");
    property p_mb_data;
        b_mr && word_b |=> b_data_out[17:0] == $past(mbx_q[17:0]);
    endproperty
    a_mb_data: assert property (p_mb_data)
        else $error("forward mailbox data wrong");
    c_fill: cover property (a_wr && !b_av);
    c_full: cover property ($fell(a_flags.input_ready));
    c_mbx: cover property (b_mr && a_flags.mailbox_full);
endmodule

bind dfb_top dfb_properties i_props (
    .clock(clock),
    .rst_n(rst_n),
    .bus_match_select(bus_match_select),
    .size_select(size_select),
    .endian_select(endian_select),
    .fall_through_mode(fall_through_mode),
    .a_ctl(a_ctl),
    .a_data_in(a_data_in),
    .a_data_out(a_data_out),
    .a_flags(a_flags),
    .b_ctl(b_ctl),
    .b_data_in(b_data_in),
    .b_data_out(b_data_out),
    .b_flags(b_flags)
);

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dfb_pkg::*;
    // ****************
    // Stimulus and checking
    // ****************
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic bus_match_select = 1'h0;
    logic size_select = 1'h0;
    logic endian_select = 1'h0;
    logic fall_through_mode = 1'h0;
    dfb_ctl_t a_ctl = 4'h8;
    dfb_ctl_t t_bctl = 4'h8;
    dfb_ctl_t m_bctl;
    logic [35:0] a_data_in = 36'h0;
    logic [35:0] b_data_in = 36'h0;
    logic [35:0] a_data_out;
    logic [35:0] b_data_out;
    dfb_flags_t a_flags;
    dfb_flags_t b_flags;
    logic use_tb = 1'h1;
    logic rd_go = 1'h0;
    logic pend_a = 1'h0;
    logic pend_b = 1'h0;
    logic [31:0] seed = 32'h7f9c;
    logic [35:0] exp_a[$];
    logic [35:0] exp_b[$];
    logic [3:0] cfgs[4] = '{4'hf, 4'hc, 4'ha, 4'h1};
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    wire dfb_ctl_t b_ctl = use_tb ? t_bctl : m_bctl;
    wire a_take = a_ctl == 4'h1 && (a_flags.output_ready || a_flags.empty_n);
    wire b_take = b_ctl == 4'h5 && (b_flags.output_ready || b_flags.empty_n);

    dfb_top i_dut (.clock(clock), .rst_n(rst_n),
        .bus_match_select(bus_match_select), .size_select(size_select),
        .endian_select(endian_select), .fall_through_mode(fall_through_mode),
        .a_ctl(a_ctl), .a_data_in(a_data_in), .a_data_out(a_data_out),
        .a_flags(a_flags), .b_ctl(b_ctl), .b_data_in(b_data_in),
        .b_data_out(b_data_out), .b_flags(b_flags));
    dfb_b_reader i_reader (.clock(clock), .rst_n(rst_n), .rd_go(rd_go),
        .b_flags(b_flags), .b_ctl(m_bctl));

    always #25 clock = ~clock;

    task automatic end_sim();
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cycle ceiling against hangs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            end_sim();
        end
    end

    function automatic logic [35:0] rnd36();
        logic [31:0] hi;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        hi = seed;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return {hi[3:0], seed};
    endfunction

    task automatic cmp_data(input logic [35:0] got, input logic [35:0] want);
        tests_run++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic want);
        cmp_data({35'h0, got}, {35'h0, want});
    endtask

    task automatic pop_cmp(input logic [35:0] got, ref logic [35:0] q[$]);
        if (q.size() == 0) begin
            cmp_data(got, ~got);
        end else begin
            cmp_data(got, q.pop_front());
        end
    endtask

    // Port B pieces of one forward entry, in delivery order
    task automatic push_fwd(input logic [35:0] d);
        int n;
        int k;
        n = !bus_match_select ? 1 : (size_select ? 4 : 2);
        for (int i = 0; i < n; i++) begin
            k = endian_select ? n - 1 - i : i;
            if (n == 1) exp_b.push_back(d);
            else if (n == 2) exp_b.push_back({18'h0, d[k*18 +: 18]});
            else exp_b.push_back({27'h0, d[k*9 +: 9]});
        end
    endtask

    task automatic a_op(input logic dir, mbx, input logic [35:0] d);
        @(negedge clock);
        a_ctl <= {1'h0, dir, mbx, 1'h1};
        a_data_in <= d;
    endtask

    task automatic b_op(input logic dir, mbx, input logic [35:0] d);
        @(negedge clock);
        t_bctl <= {1'h0, dir, mbx, 1'h1};
        b_data_in <= d;
    endtask

    task automatic idle();
        @(negedge clock);
        a_ctl <= 4'h8;
        t_bctl <= 4'h8;
    endtask

    task automatic cfg(input logic [3:0] c);
        @(negedge clock);
        rst_n <= 1'h0;
        {bus_match_select, size_select, endian_select, fall_through_mode} <= c;
        repeat (6) @(negedge clock);
        rst_n <= 1'h1;
        repeat (2) @(negedge clock);
    endtask

    // Reverse entry sent as two words, junk on the unused lines
    task automatic b_entry(input logic [35:0] d);
        logic [35:0] j;
        for (int i = 0; i < 2; i++) begin
            j = rnd36();
            b_op(1'h0, 1'h0, {j[35:18], d[(endian_select ? 1 - i : i)*18 +: 18]});
        end
        exp_a.push_back(d);
    endtask

    task automatic wait_b();
        for (int t = 0; t < 3000 && (exp_b.size() > 0 || pend_b); t++)
            @(negedge clock);
        cmp_flag(exp_b.size() == 0, 1'h1);
    endtask

    task automatic a_drain();
        for (int t = 0; t < 200 && exp_a.size() > 0; t++) begin
            @(negedge clock);
            a_ctl <= (a_flags.output_ready || a_flags.empty_n) ? 4'h1 : 4'h8;
        end
        idle();
    endtask

    // Results taken off the expectation queues as they appear
    always @(posedge clock) begin
        if (pend_b || (b_take && fall_through_mode)) pop_cmp(b_data_out, exp_b);
        if (pend_a || (a_take && fall_through_mode)) pop_cmp(a_data_out, exp_a);
        pend_b <= rst_n && b_take && !fall_through_mode;
        pend_a <= rst_n && a_take && !fall_through_mode;
    end

    initial begin
        logic [35:0] d;
        use_tb = 1'h0;
        rd_go = 1'h1;
        foreach (cfgs[c]) begin
            cfg(cfgs[c]);
            for (int i = 0; i < 3; i++) begin
                d = rnd36();
                push_fwd(d);
                a_op(1'h1, 1'h0, d);
            end
            idle();
            wait_b();
        end
        rd_go = 1'h0;
        for (int i = 0; i < 257; i++) begin
            d = rnd36();
            if (i < 256) push_fwd(d);
            a_op(1'h1, 1'h0, d);
        end
        idle();
        repeat (4) @(negedge clock);
        cmp_flag(a_flags.input_ready, 1'h0);
        cmp_flag(a_flags.almost_full_n, 1'h0);
        rd_go = 1'h1;
        wait_b();
        cmp_flag(a_flags.input_ready, 1'h1);
        cmp_flag(a_flags.almost_full_n, 1'h1);
        cmp_flag(b_flags.almost_empty_n, 1'h0);
        rd_go = 1'h0;
        use_tb = 1'h1;
        for (int e = 0; e < 2; e++) begin
            cfg({3'h4 | 3'(e), 1'h1});
            b_entry(rnd36());
            b_entry(rnd36());
            idle();
            repeat (6) @(negedge clock);
            cmp_flag(b_flags.input_ready, 1'h1);
            cmp_flag(b_flags.almost_full_n, 1'h1);
            cmp_flag(a_flags.almost_empty_n, 1'h0);
            a_drain();
            d = rnd36();
            a_op(1'h1, 1'h1, d);
            idle();
            repeat (3) @(negedge clock);
            cmp_flag(a_flags.mailbox_full, 1'h1);
            b_op(1'h1, 1'h1, 36'h0);
            idle();
            cmp_data(b_data_out, {18'h0, d[17:0]});
            repeat (3) @(negedge clock);
            cmp_flag(a_flags.mailbox_full, 1'h0);
            b_op(1'h0, 1'h1, d);
            idle();
            a_op(1'h0, 1'h1, 36'h0);
            idle();
            cmp_data(a_data_out, {18'h0, d[17:0]});
            cmp_flag(b_flags.mailbox_full, 1'h1);
            repeat (2) @(negedge clock);
            cmp_flag(b_flags.mailbox_full, 1'h0);
        end
        end_sim();
    end
endmodule
